// *** ssr_pkg.sv ***
package ssr_pkg;

  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int INSTR_W = 16;
  localparam int CNT_W = 4;

  // instruction word: read flag on top, then the register address
  localparam int RW_BIT = 15;
  localparam logic [CNT_W-1:0] INSTR_LAST = 4'hf;
  localparam logic [CNT_W-1:0] DATA_LAST = 4'h7;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_STEP = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 15'h0001;

  localparam logic [ADDR_W-1:0] OFF_STATUS = 15'h0049;
  localparam logic [ADDR_W-1:0] OFF_RSVD_A = 15'h004a;
  localparam logic [ADDR_W-1:0] OFF_CORE = 15'h004b;
  localparam logic [ADDR_W-1:0] OFF_TEMP_MAG = 15'h004c;
  localparam logic [ADDR_W-1:0] OFF_TEMP_SIGN = 15'h004d;
  localparam logic [ADDR_W-1:0] OFF_RSVD_B = 15'h004e;
  localparam logic [ADDR_W-1:0] OFF_BAND = 15'h004f;
  localparam logic [ADDR_W-1:0] OFF_RSVD_C = 15'h0050;
  localparam logic [ADDR_W-1:0] OFF_BIAS = 15'h0051;
  localparam logic [ADDR_W-1:0] OFF_RSVD_D = 15'h0052;
  localparam logic [ADDR_W-1:0] OFF_RSVD_E = 15'h0053;
  localparam logic [ADDR_W-1:0] OFF_REVISION = 15'h0054;

  localparam int BIT_PULSE_PIN = 7;
  localparam int BIT_CLK_PIN = 6;
  localparam int BIT_WINDOW = 5;
  localparam int BIT_REF_AMP = 3;
  localparam int BIT_CONV_BUSY = 2;
  localparam int BIT_CAL_BUSY = 1;
  localparam int BIT_LOCK = 0;

  localparam int CORE_W = 2;
  localparam int BAND_W = 8;
  localparam int BIAS_W = 4;
  localparam int TEMP_W = 8;

  localparam logic [DATA_W-1:0] REG_RST = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INSTR = 2'b01,
    ST_DATA = 2'b10
  } ssr_state_type;

endpackage : ssr_pkg

// *** ssr_reg_if.sv ***
`timescale 1ns/1ps
interface ssr_reg_if;
  logic [ssr_pkg::ADDR_W-1:0] addr;
  logic [ssr_pkg::DATA_W-1:0] status;
  logic [ssr_pkg::CORE_W-1:0] core_code;
  logic [ssr_pkg::TEMP_W-1:0] temp_mag;
  logic temp_neg;
  logic [ssr_pkg::BAND_W-1:0] band_code;
  logic [ssr_pkg::BIAS_W-1:0] bias_code;
  logic [ssr_pkg::DATA_W-1:0] revision;
  logic [ssr_pkg::DATA_W-1:0] rd_data;

  modport engine (
    output addr,
    output status,
    output core_code,
    output temp_mag,
    output temp_neg,
    output band_code,
    output bias_code,
    output revision,
    input rd_data
  );

  modport decode (
    input addr,
    input status,
    input core_code,
    input temp_mag,
    input temp_neg,
    input band_code,
    input bias_code,
    input revision,
    output rd_data
  );
endinterface : ssr_reg_if

// *** ssr_regmux.sv ***
`timescale 1ns/1ps
module ssr_regmux (
  ssr_reg_if.decode regs
);

  // reserved and unmapped offsets read as zero
  always_comb begin
    regs.rd_data = ssr_pkg::READ_ZERO;
    case (regs.addr)
      ssr_pkg::OFF_STATUS: begin
        regs.rd_data = regs.status;
      end
      ssr_pkg::OFF_CORE: begin
        regs.rd_data[ssr_pkg::CORE_W-1:0] = regs.core_code;
      end
      ssr_pkg::OFF_TEMP_MAG: begin
        regs.rd_data = regs.temp_mag;
      end
      ssr_pkg::OFF_TEMP_SIGN: begin
        regs.rd_data[0] = regs.temp_neg;
      end
      ssr_pkg::OFF_BAND: begin
        regs.rd_data = regs.band_code;
      end
      ssr_pkg::OFF_BIAS: begin
        regs.rd_data[ssr_pkg::BIAS_W-1:0] = regs.bias_code;
      end
      ssr_pkg::OFF_REVISION: begin
        regs.rd_data = regs.revision;
      end
      default: begin
        regs.rd_data = ssr_pkg::READ_ZERO;
      end
    endcase
  end

endmodule : ssr_regmux

// *** ssr_status_readback.sv ***
// Operation
// - status bit 7 shows the synchronised pulse-path enable pin level, resets zero
// - status bit 6 shows the synchronised clock-output enable pin level
// - status bit 5 is one while the pulse input meets its timing window
// - status bit 3 is one while reference amplitude exceeds threshold
// - status bit 2 is one throughout a converter conversion
// - status bit 1 is one while calibration runs, zero when idle
// - core readback holds the two-bit core code, upper bits zero
// - temperature: magnitude in one register, sign bit 0 of the next
// - band readback returns the full eight-bit band code in use
// - bias readback holds the four-bit bias code, upper nibble zero
`timescale 1ns/1ps
module ssr_status_readback #(
  // arbitrary value, not a real die code
  parameter logic [7:0] DIE_REVISION = 8'h5a
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic SPI_CS_N,
  input wire logic SPI_SCLK,
  input wire logic SPI_SDI,
  output logic SPI_SDO,
  output logic SPI_SDO_OE,
  input wire logic PULSE_PATH_ENABLE_PIN,
  input wire logic CLOCK_OUTPUT_ENABLE_PIN,
  input wire logic PULSE_WINDOW_GOOD,
  input wire logic REF_AMPLITUDE_OK,
  input wire logic CONV_BUSY,
  input wire logic CALIBRATION_BUSY,
  input wire logic LOCK_DETECT,
  input wire logic [1:0] OSC_CORE_CODE,
  input wire logic [7:0] OSC_BAND_CODE,
  input wire logic [3:0] OSC_BIAS_CODE,
  input wire logic [7:0] TEMP_MAGNITUDE,
  input wire logic TEMP_NEGATIVE
);

  localparam int AW = ssr_pkg::ADDR_W;
  localparam int DW = ssr_pkg::DATA_W;

  ssr_reg_if reg_if ();

  // ---------------- status levels ----------------
  // analog monitors are not on this clock, so every level is synchronised
  logic [DW-1:0] stat_raw;
  logic [DW-1:0] stat_sync;

  always_comb begin
    stat_raw = ssr_pkg::REG_RST;
    stat_raw[ssr_pkg::BIT_PULSE_PIN] = PULSE_PATH_ENABLE_PIN;
    stat_raw[ssr_pkg::BIT_CLK_PIN] = CLOCK_OUTPUT_ENABLE_PIN;
    stat_raw[ssr_pkg::BIT_WINDOW] = PULSE_WINDOW_GOOD;
    stat_raw[ssr_pkg::BIT_REF_AMP] = REF_AMPLITUDE_OK;
    stat_raw[ssr_pkg::BIT_CONV_BUSY] = CONV_BUSY;
    stat_raw[ssr_pkg::BIT_CAL_BUSY] = CALIBRATION_BUSY;
    stat_raw[ssr_pkg::BIT_LOCK] = LOCK_DETECT;
  end

  ssr_sync #(
    .WIDTH(DW)
  ) u_stat_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .d(stat_raw),
    .q(stat_sync)
  );

  // ---------------- serial pins ----------------
  // chip select is inverted so that the reset value means deselected
  logic [2:0] spi_sync;
  logic cs_s;
  logic sclk_s;
  logic sdi_s;

  ssr_sync #(
    .WIDTH(3)
  ) u_spi_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .d({~SPI_CS_N, SPI_SCLK, SPI_SDI}),
    .q(spi_sync)
  );

  assign cs_s = spi_sync[2];
  assign sclk_s = spi_sync[1];
  assign sdi_s = spi_sync[0];

  // ---------------- readback registers ----------------
  logic [DW-1:0] status_r;
  logic [DW-1:0] status_nxt;
  logic [1:0] core_r;
  logic [1:0] core_nxt;
  logic [7:0] band_r;
  logic [7:0] band_nxt;
  logic [3:0] bias_r;
  logic [3:0] bias_nxt;
  logic [7:0] tmag_r;
  logic [7:0] tmag_nxt;
  logic tneg_r;
  logic tneg_nxt;

  // values follow their sources every cycle; nothing on the port stores
  always_comb begin
    if (!RST_N) begin
      status_nxt = ssr_pkg::REG_RST;
      core_nxt = '0;
      band_nxt = '0;
      bias_nxt = '0;
      tmag_nxt = '0;
      tneg_nxt = 1'b0;
    end else begin
      status_nxt = stat_sync;
      core_nxt = OSC_CORE_CODE;
      band_nxt = OSC_BAND_CODE;
      bias_nxt = OSC_BIAS_CODE;
      tmag_nxt = TEMP_MAGNITUDE;
      tneg_nxt = TEMP_NEGATIVE;
    end
  end

  always_ff @(posedge MCLK) begin
    status_r <= status_nxt;
    core_r <= core_nxt;
    band_r <= band_nxt;
    bias_r <= bias_nxt;
    tmag_r <= tmag_nxt;
    tneg_r <= tneg_nxt;
  end

  // ---------------- serial engine ----------------
  ssr_pkg::ssr_state_type state_r;
  ssr_pkg::ssr_state_type state_nxt;
  logic [ssr_pkg::CNT_W-1:0] cnt_r;
  logic [ssr_pkg::CNT_W-1:0] cnt_nxt;
  logic [ssr_pkg::INSTR_W-1:0] instr_r;
  logic [ssr_pkg::INSTR_W-1:0] instr_nxt;
  logic [AW-1:0] addr_r;
  logic [AW-1:0] addr_nxt;
  logic read_r;
  logic read_nxt;
  logic [DW-1:0] tx_r;
  logic [DW-1:0] tx_nxt;
  logic sclk_d_r;
  logic sclk_d_nxt;
  logic oe_r;
  logic oe_nxt;
  logic sclk_rise;
  logic sclk_fall;

  // edges taken from the second synchroniser stage; the host must hold
  // each clock phase for at least three system clocks
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    instr_nxt = instr_r;
    addr_nxt = addr_r;
    read_nxt = read_r;
    tx_nxt = tx_r;
    sclk_d_nxt = sclk_s;
    oe_nxt = oe_r;
    if (!RST_N) begin
      state_nxt = ssr_pkg::ST_IDLE;
      cnt_nxt = ssr_pkg::CNT_ZERO;
      instr_nxt = '0;
      addr_nxt = '0;
      read_nxt = 1'b0;
      tx_nxt = ssr_pkg::REG_RST;
      sclk_d_nxt = 1'b0;
      oe_nxt = 1'b0;
    end else if (!cs_s) begin
      state_nxt = ssr_pkg::ST_IDLE;
      cnt_nxt = ssr_pkg::CNT_ZERO;
      oe_nxt = 1'b0;
    end else begin
      unique case (state_r)
        ssr_pkg::ST_IDLE: begin
          state_nxt = ssr_pkg::ST_INSTR;
          cnt_nxt = ssr_pkg::CNT_ZERO;
        end
        ssr_pkg::ST_INSTR: begin
          if (sclk_rise) begin
            instr_nxt = {instr_r[ssr_pkg::INSTR_W-2:0], sdi_s};
            cnt_nxt = cnt_r + ssr_pkg::CNT_STEP;
            if (cnt_r == ssr_pkg::INSTR_LAST) begin
              state_nxt = ssr_pkg::ST_DATA;
              cnt_nxt = ssr_pkg::CNT_ZERO;
              read_nxt = instr_r[ssr_pkg::RW_BIT-1];
              addr_nxt = {instr_r[AW-2:0], sdi_s};
            end
          end
        end
        ssr_pkg::ST_DATA: begin
          if (sclk_fall && read_r) begin
            oe_nxt = 1'b1;
            if (cnt_r == ssr_pkg::CNT_ZERO) begin
              tx_nxt = reg_if.rd_data;
            end else begin
              tx_nxt = {tx_r[DW-2:0], 1'b0};
            end
          end
          // write bits are counted for streaming but never stored
          if (sclk_rise) begin
            cnt_nxt = cnt_r + ssr_pkg::CNT_STEP;
            if (cnt_r == ssr_pkg::DATA_LAST) begin
              cnt_nxt = ssr_pkg::CNT_ZERO;
              addr_nxt = addr_r + ssr_pkg::ADDR_STEP;
            end
          end
        end
        default: begin
          state_nxt = ssr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    state_r <= state_nxt;
    cnt_r <= cnt_nxt;
    instr_r <= instr_nxt;
    addr_r <= addr_nxt;
    read_r <= read_nxt;
    tx_r <= tx_nxt;
    sclk_d_r <= sclk_d_nxt;
    oe_r <= oe_nxt;
  end

  assign SPI_SDO = tx_r[DW-1];
  assign SPI_SDO_OE = oe_r;

  // ---------------- register decode ----------------
  assign reg_if.addr = addr_r;
  assign reg_if.status = status_r;
  assign reg_if.core_code = core_r;
  assign reg_if.temp_mag = tmag_r;
  assign reg_if.temp_neg = tneg_r;
  assign reg_if.band_code = band_r;
  assign reg_if.bias_code = bias_r;
  assign reg_if.revision = DIE_REVISION;

  ssr_regmux u_regmux (
    .regs(reg_if.decode)
  );

  // ---------------- checks ----------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_held(sig);
    $stable(sig) [*4];
  endsequence

  sequence s_rise_kept(sig);
    $rose(sig) ##1 sig [*2];
  endsequence

  a_pulse_pin_bit: assert property (
    s_held(PULSE_PATH_ENABLE_PIN) |->
      status_r[ssr_pkg::BIT_PULSE_PIN] == PULSE_PATH_ENABLE_PIN)
    else $error("pulse enable status bit does not follow its pin");

  a_clk_pin_bit: assert property (
    s_held(CLOCK_OUTPUT_ENABLE_PIN) |->
      status_r[ssr_pkg::BIT_CLK_PIN] == CLOCK_OUTPUT_ENABLE_PIN)
    else $error("clock enable status bit does not follow its pin");

  a_window_good_bit: assert property (
    s_rise_kept(PULSE_WINDOW_GOOD) |->
      ##1 status_r[ssr_pkg::BIT_WINDOW])
    else $error("window good bit late after rise");

  a_ref_amp_bit: assert property (
    $fell(REF_AMPLITUDE_OK) ##1 (!REF_AMPLITUDE_OK) [*2] |->
      ##1 !status_r[ssr_pkg::BIT_REF_AMP])
    else $error("amplitude bit stays set after drop");

  a_conv_busy_bit: assert property (
    CONV_BUSY [*4] |-> status_r[ssr_pkg::BIT_CONV_BUSY])
    else $error("converter busy bit missing during conversion");

  a_cal_idle_bit: assert property (
    (!CALIBRATION_BUSY) [*4] |-> !status_r[ssr_pkg::BIT_CAL_BUSY])
    else $error("calibration busy bit set while idle");

  a_lock_bit: assert property (
    s_held(LOCK_DETECT) |-> status_r[ssr_pkg::BIT_LOCK] == LOCK_DETECT)
    else $error("lock bit does not mirror lock detector");

  a_core_readback: assert property (
    reg_if.addr == ssr_pkg::OFF_CORE |->
      reg_if.rd_data == {6'h00, $past(OSC_CORE_CODE)})
    else $error("core readback wrong or upper bits set");

  a_temp_sign_read: assert property (
    reg_if.addr == ssr_pkg::OFF_TEMP_SIGN |->
      reg_if.rd_data == {7'h00, $past(TEMP_NEGATIVE)})
    else $error("temperature sign readback wrong");

  a_temp_mag_read: assert property (
    reg_if.addr == ssr_pkg::OFF_TEMP_MAG |->
      reg_if.rd_data == $past(TEMP_MAGNITUDE))
    else $error("temperature magnitude readback wrong");

  a_band_readback: assert property (
    reg_if.addr == ssr_pkg::OFF_BAND |->
      reg_if.rd_data == $past(OSC_BAND_CODE))
    else $error("band readback wrong");

  a_bias_readback: assert property (
    reg_if.addr == ssr_pkg::OFF_BIAS |->
      reg_if.rd_data == {4'h0, $past(OSC_BIAS_CODE)})
    else $error("bias readback wrong or upper nibble set");

  a_write_no_drive: assert property (
    (state_r == ssr_pkg::ST_DATA && !read_r) |-> !SPI_SDO_OE)
    else $error("data line driven during a write");

  // a fall that lands together with the deselect is dropped, not launched
  a_read_launch: assert property (
    (state_r == ssr_pkg::ST_DATA && read_r && cs_s && sclk_fall &&
      cnt_r == ssr_pkg::CNT_ZERO) |=>
      SPI_SDO == $past(reg_if.rd_data[DW-1]) && SPI_SDO_OE)
    else $error("first read bit not launched");

  a_read_shift: assert property (
    (state_r == ssr_pkg::ST_DATA && read_r && cs_s && sclk_fall &&
      cnt_r != ssr_pkg::CNT_ZERO) |=> SPI_SDO == $past(tx_r[DW-2]))
    else $error("read bit not shifted on clock fall");

  a_addr_step: assert property (
    (state_r == ssr_pkg::ST_DATA && cs_s && sclk_rise &&
      cnt_r == ssr_pkg::DATA_LAST) |=>
      addr_r == $past(addr_r) + ssr_pkg::ADDR_STEP)
    else $error("address not stepped after a full byte");

  a_deselect_quiet: assert property (
    !cs_s |=> !SPI_SDO_OE)
    else $error("data line still driven after deselect");

endmodule : ssr_status_readback

// *** ssr_status_readback_bench.sv ***
`timescale 1ns/1ps
module ssr_status_readback_bench;
  // arbitrary value, not a real die code
  localparam logic [7:0] REV = 8'h5a;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n = 1'b1;
  logic sclk = 1'b0;
  logic sdi = 1'b0;
  logic sdo;
  logic sdo_oe;
  // {pulse pin, clk pin, window, spare, ref, conv, cal, lock}
  logic [7:0] stat_in = 8'h00;
  logic [1:0] core = 2'h0;
  logic [7:0] band = 8'h00;
  logic [3:0] bias = 4'h0;
  logic [7:0] mag = 8'h00;
  logic neg = 1'b0;
  logic [7:0] rx_q[$];
  int n_errors = 0;
  int checks = 0;

  always #5 mclk = ~mclk;

  ssr_status_readback #(
    .DIE_REVISION(REV)
  ) dut_u (
    .MCLK(mclk),
    .RST_N(rst_n),
    .SPI_CS_N(cs_n),
    .SPI_SCLK(sclk),
    .SPI_SDI(sdi),
    .SPI_SDO(sdo),
    .SPI_SDO_OE(sdo_oe),
    .PULSE_PATH_ENABLE_PIN(stat_in[7]),
    .CLOCK_OUTPUT_ENABLE_PIN(stat_in[6]),
    .PULSE_WINDOW_GOOD(stat_in[5]),
    .REF_AMPLITUDE_OK(stat_in[3]),
    .CONV_BUSY(stat_in[2]),
    .CALIBRATION_BUSY(stat_in[1]),
    .LOCK_DETECT(stat_in[0]),
    .OSC_CORE_CODE(core),
    .OSC_BAND_CODE(band),
    .OSC_BIAS_CODE(bias),
    .TEMP_MAGNITUDE(mag),
    .TEMP_NEGATIVE(neg)
  );

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask : check_byte

  task automatic check_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t bit got %b exp %b", $time, got, exp);
    end
  endtask : check_bit

  task automatic give_verdict();
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  // every wait ends on a falling edge, so all drives land off the sampling edge
  task automatic cycles(input int n);
    repeat (n) @(negedge mclk);
  endtask : cycles

  // low phase 6 cycles: sdo moves 2-3 cycles after the fall, so it has settled
  task automatic spi_bit(input logic b, output logic rd, output logic en);
    sdi = b;
    cycles(6);
    rd = sdo;
    en = sdo_oe;
    sclk = 1'b1;
    cycles(4);
    sclk = 1'b0;
  endtask : spi_bit

  task automatic spi_frame(input logic rd_op, input logic [14:0] addr,
                           input int nbytes, input logic [7:0] wdata);
    logic [15:0] instr;
    logic [7:0] byte_v;
    logic b;
    logic en;
    instr = {rd_op, addr};
    rx_q.delete();
    cs_n = 1'b0;
    cycles(4);
    for (int i = 15; i >= 0; i--) begin
      spi_bit(instr[i], b, en);
    end
    for (int k = 0; k < nbytes; k++) begin
      for (int i = 7; i >= 0; i--) begin
        spi_bit(rd_op ? 1'b0 : wdata[i], b, en);
        byte_v[i] = b;
        check_bit(en, rd_op);
      end
      rx_q.push_back(byte_v);
    end
    cs_n = 1'b1;
    cycles(4);
    check_bit(sdo_oe, 1'b0);
    cycles(2);
  endtask : spi_frame

  task automatic read_cmp(input logic [14:0] addr, input logic [7:0] exp);
    spi_frame(1'b1, addr, 1, 8'h00);
    check_byte(rx_q[0], exp);
  endtask : read_cmp

  initial begin
    #500000;
    n_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    cycles(4);
    rst_n = 1'b1;
    cycles(1);
    // whole readback range in one streamed frame, straight after reset
    spi_frame(1'b1, ssr_pkg::OFF_STATUS, 12, 8'h00);
    for (int k = 0; k < 12; k++) begin
      check_byte(rx_q[k], (k == 11) ? REV : 8'h00);
    end
    // walk a single one through the status inputs, then all ones
    for (int i = 0; i < 9; i++) begin
      stat_in = (i < 8) ? (8'h01 << i) : 8'hff;
      cycles(4);
      read_cmp(ssr_pkg::OFF_STATUS, stat_in & 8'hef);
    end
    for (int s = 0; s < 2; s++) begin
      core = s ? 2'h2 : 2'h3;
      band = s ? 8'h5a : 8'ha5;
      bias = s ? 4'h3 : 4'hc;
      mag = s ? 8'hff : 8'h3c;
      neg = s ? 1'b0 : 1'b1;
      cycles(4);
      spi_frame(1'b1, ssr_pkg::OFF_CORE, 7, 8'h00);
      check_byte(rx_q[0], {6'h00, core});
      check_byte(rx_q[1], mag);
      check_byte(rx_q[2], {7'h00, neg});
      check_byte(rx_q[3], 8'h00);
      check_byte(rx_q[4], band);
      check_byte(rx_q[5], 8'h00);
      check_byte(rx_q[6], {4'h0, bias});
    end
    // writes into the read-only range must leave every value alone
    spi_frame(1'b0, ssr_pkg::OFF_STATUS, 1, 8'h10);
    spi_frame(1'b0, ssr_pkg::OFF_BAND, 2, 8'ha5);
    spi_frame(1'b0, ssr_pkg::OFF_RSVD_A, 1, 8'hff);
    read_cmp(ssr_pkg::OFF_STATUS, 8'hef);
    read_cmp(ssr_pkg::OFF_BAND, 8'h5a);
    read_cmp(ssr_pkg::OFF_RSVD_A, 8'h00);
    read_cmp(ssr_pkg::OFF_REVISION, REV);
    read_cmp(15'h0000, 8'h00);
    read_cmp(15'h7fff, 8'h00);
    // second reset in mid-run: serial output must go quiet
    rst_n = 1'b0;
    stat_in = 8'h00;
    cycles(4);
    check_bit(sdo, 1'b0);
    check_bit(sdo_oe, 1'b0);
    rst_n = 1'b1;
    cycles(1);
    read_cmp(ssr_pkg::OFF_STATUS, 8'h00);
    give_verdict();
  end
endmodule : ssr_status_readback_bench

// *** ssr_sync.sv ***
`timescale 1ns/1ps
module ssr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  if (WIDTH < 1) begin : g_bad_width
    $error("ssr_sync needs a width of at least one");
  end

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;

  // first stage feeds only the second stage
  always_comb begin
    meta_nxt = rst_n ? d : '0;
    q_nxt = rst_n ? meta_r : '0;
  end

  always_ff @(posedge clk) begin
    meta_r <= meta_nxt;
    q_r <= q_nxt;
  end

  assign q = q_r;

endmodule : ssr_sync
